// >>> swdc_pkg.sv
// Shared constants and types of the single-wire debug command port
// ************************************************************
// Notes on behaviour
// - To send 0, hold line low 13 cycles from bit start, then speedup pulse.
// - Host falling edge is synchronised into the debug clock before use.
// - Every command but the speed probe opens with 8-bit code, MSB first.
// - Delay slot gives the target 16 cycles to carry out the operation.
// - Non-intrusive codes always accepted; halted-only codes only while halted.
// - Address 16 bits in; byte data 8 bits; word data 16 bits.
// - E4 returns status/control byte; C4 loads it from received control byte.
// - Code 90 halts the CPU only when the debug mode enable bit is set.
// - E0 reads byte; E1 adds status first; E8 re-reads last read address.
// - C0 writes byte during delay; C1 also returns status afterwards.
// - E2 returns match register, C2 loads it; no delay slot for either.
// - Halted codes 08 resume, 10 single step, 18 resume with tagging.
// - Codes 68/69 return byte registers, 6B/6C/6F return word registers.
// - Codes 48/49 load byte registers, 4B/4C/4F load word registers.
// - Code 70 bumps index pair then reads byte there; 71 adds status.
// - Code 50 bumps index pair then writes byte there; 51 adds status.
// - After long low: wait high, wait 16, drive low 128, 1-cycle pulse.
// - Nominal bit is 16 cycles; 512 cycles without host edge aborts command.
// - Host-sent bits are sampled 10 cycles after bit start; no drive then.
// - To send 1, leave line alone and pulse high 7 cycles after bit start.
// ************************************************************
`default_nettype none
package swdc_pkg;
  // ************************************************************
  // Timing, in debug clock cycles
  // ************************************************************
  typedef logic [9:0] swdc_cnt_t;
  localparam swdc_cnt_t BIT_NOMINAL_CYC = 10'h010;
  localparam swdc_cnt_t TX0_LOW_CYC = 10'h00D;
  localparam swdc_cnt_t TX1_PULSE_AT = 10'h007;
  localparam swdc_cnt_t RX_SAMPLE_AT = 10'h00A;
  localparam swdc_cnt_t SYNC_REQ_MIN_CYC = 10'h080;
  localparam swdc_cnt_t SYNC_GAP_CYC = 10'h010;
  localparam swdc_cnt_t SYNC_LOW_CYC = 10'h080;
  localparam swdc_cnt_t TIMEOUT_CYC = 10'h200;
  // ************************************************************
  // Field lengths, control layout, register selects
  // ************************************************************
  localparam logic [4:0] LEN_BYTE_BITS = 5'h08;
  localparam logic [4:0] LEN_WORD_BITS = 5'h10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned ENABLE_BIT_POS = 7;
  localparam int unsigned HALTED_BIT_POS = 6;
  localparam logic [2:0] REG_SEL_HX = 3'h4;
  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam logic [7:0] CMD_RD_STATUS = 8'hE4;
  localparam logic [7:0] CMD_WR_CTRL = 8'hC4;
  localparam logic [7:0] CMD_MEM_RD = 8'hE0;
  localparam logic [7:0] CMD_MEM_RD_SS = 8'hE1;
  localparam logic [7:0] CMD_MEM_RD_LAST = 8'hE8;
  localparam logic [7:0] CMD_MEM_WR = 8'hC0;
  localparam logic [7:0] CMD_MEM_WR_SS = 8'hC1;
  localparam logic [7:0] CMD_RD_MATCH = 8'hE2;
  localparam logic [7:0] CMD_WR_MATCH = 8'hC2;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_TAG_GO = 8'h18;
  localparam logic [7:0] CMD_RD_ACC = 8'h68;
  localparam logic [7:0] CMD_RD_FLAGS = 8'h69;
  localparam logic [7:0] CMD_RD_PC = 8'h6B;
  localparam logic [7:0] CMD_RD_HX = 8'h6C;
  localparam logic [7:0] CMD_RD_SP = 8'h6F;
  localparam logic [7:0] CMD_WR_ACC = 8'h48;
  localparam logic [7:0] CMD_WR_FLAGS = 8'h49;
  localparam logic [7:0] CMD_WR_PC = 8'h4B;
  localparam logic [7:0] CMD_WR_HX = 8'h4C;
  localparam logic [7:0] CMD_WR_SP = 8'h4F;
  localparam logic [7:0] CMD_NEXT_RD = 8'h70;
  localparam logic [7:0] CMD_NEXT_RD_SS = 8'h71;
  localparam logic [7:0] CMD_NEXT_WR = 8'h50;
  localparam logic [7:0] CMD_NEXT_WR_SS = 8'h51;
  // ************************************************************
  // Command plan
  // ************************************************************
  typedef enum logic [1:0] {LEN_NONE, LEN_BYTE, LEN_WORD} swdc_len_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_HALT, OP_WR_CTRL, OP_MEM_RD, OP_MEM_RD_LAST, OP_MEM_WR,
    OP_RD_MATCH, OP_WR_MATCH, OP_GO, OP_STEP, OP_TAG_GO, OP_REG_RD,
    OP_REG_WR, OP_NEXT_RD, OP_NEXT_WR
  } swdc_op_t;
  typedef struct packed {
    logic valid;
    logic halted_only;
    logic need_addr;
    swdc_len_t wlen;
    swdc_op_t op;
    logic tx_ss;
    swdc_len_t rlen;
  } swdc_plan_t;
endpackage
`default_nettype wire

// >>> swdc_bit_if.sv
// Bit-level hand-off between command sequencer and line engine
`default_nettype none
interface swdc_bit_if;
  logic tx_en;
  logic tx_bit;
  logic done;
  logic rx_bit;
  logic abort;
  modport eng (input tx_en, input tx_bit, output done, output rx_bit, output abort);
  modport seq (output tx_en, output tx_bit, input done, input rx_bit, input abort);
endinterface
`default_nettype wire

// >>> swdc_bit_engine.sv
// Line engine: bit timing, speed-probe response and inactivity timeout
`default_nettype none
module swdc_bit_engine
  import swdc_pkg::*;
#(
  parameter swdc_cnt_t TIMEOUT = TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  swdc_bit_if.eng bif
);
  if (TIMEOUT <= SYNC_REQ_MIN_CYC) begin : g_chk
    $error("swdc_bit_engine: TIMEOUT must exceed the speed-probe threshold");
  end

  typedef enum logic [2:0] {
    E_IDLE, E_RX, E_TX0, E_TX1, E_SYNC_WAIT, E_SYNC_GAP, E_SYNC_LOW, E_SYNC_PULSE
  } swdc_eng_t;
  typedef struct packed {
    swdc_eng_t st;
    logic s1;
    logic s2;
    logic s3;
    swdc_cnt_t cnt;
    swdc_cnt_t low;
    swdc_cnt_t idle;
    logic out;
    logic oe;
    logic done;
    logic rx;
    logic abort;
  } swdc_eng_state_t;

  swdc_eng_state_t q, n;
  logic fall;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.abort = 1'b0;
    // Only s2 and s3 feed logic; s1 is the metastability stage
    n.s1 = line_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    fall = q.s3 & ~q.s2;
    n.low = q.s2 ? '0 : ((q.low == SYNC_REQ_MIN_CYC) ? q.low : q.low + 10'h001);
    // ************************************************************
    // Inactivity timeout, fires once per silence
    // ************************************************************
    if (fall) begin
      n.idle = '0;
    end else if (q.idle != TIMEOUT) begin
      n.idle = q.idle + 10'h001;
    end
    if (!fall && q.idle == TIMEOUT - 10'h001) begin
      n.abort = 1'b1;
    end
    unique case (q.st)
      E_IDLE: begin
        if (fall) begin
          n.cnt = '0;
          if (bif.tx_en && !bif.tx_bit) begin
            n.st = E_TX0;
            n.oe = 1'b1;
            n.out = 1'b0;
          end else if (bif.tx_en) begin
            n.st = E_TX1;
          end else begin
            n.st = E_RX;
          end
        end
      end
      E_RX: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == RX_SAMPLE_AT - 10'h001) begin
          n.rx = q.s2;
          n.done = 1'b1;
          n.st = E_IDLE;
        end
      end
      E_TX0: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == TX0_LOW_CYC - 10'h001) begin
          n.out = 1'b1;
        end
        if (q.cnt == TX0_LOW_CYC) begin
          n.oe = 1'b0;
          n.out = 1'b0;
          n.done = 1'b1;
          n.st = E_IDLE;
        end
      end
      E_TX1: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == TX1_PULSE_AT - 10'h001) begin
          n.oe = 1'b1;
          n.out = 1'b1;
        end
        if (q.cnt == TX1_PULSE_AT) begin
          n.oe = 1'b0;
          n.out = 1'b0;
          n.done = 1'b1;
          n.st = E_IDLE;
        end
      end
      E_SYNC_WAIT: begin
        n.cnt = '0;
        if (q.s2) begin
          n.st = E_SYNC_GAP;
        end
      end
      E_SYNC_GAP: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == SYNC_GAP_CYC - 10'h001) begin
          n.cnt = '0;
          n.oe = 1'b1;
          n.out = 1'b0;
          n.st = E_SYNC_LOW;
        end
      end
      E_SYNC_LOW: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == SYNC_LOW_CYC - 10'h001) begin
          n.out = 1'b1;
          n.st = E_SYNC_PULSE;
        end
      end
      E_SYNC_PULSE: begin
        n.oe = 1'b0;
        n.out = 1'b0;
        n.st = E_IDLE;
      end
    endcase
    // Checked only in E_IDLE and E_RX, never during our own drive, but s2 lags, so our own 128-cycle sync low trips it in the E_IDLE cycle after the pulse
    if ((q.st == E_IDLE || q.st == E_RX) && !q.s2 && q.low == SYNC_REQ_MIN_CYC - 10'h001) begin
      n.st = E_SYNC_WAIT;
      n.abort = 1'b1;
      n.done = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '{st: E_IDLE, s1: 1'b1, s2: 1'b1, s3: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign line_out = q.out;
  assign line_oe = q.oe;
  assign bif.done = q.done;
  assign bif.rx_bit = q.rx;
  assign bif.abort = q.abort;
endmodule // swdc_bit_engine
`default_nettype wire

// >>> swdc_port.sv
// Target-side debug command port: command decode, sequencing and execution
`default_nettype none
module swdc_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic debug_line_in,
  output logic debug_line_out,
  output logic debug_line_oe,
  input wire logic cpu_halted,
  input wire logic [15:0] cpu_hx,
  output logic halt_req,
  output logic resume_req,
  output logic step_req,
  output logic tag_req,
  output logic [2:0] reg_sel,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] match_addr,
  output logic [7:0] status_ctrl
);
  import swdc_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic swdc_plan_t decode(input logic [7:0] c);
    swdc_plan_t p;
    p = '{valid: 1'b1, halted_only: 1'b0, need_addr: 1'b0, wlen: LEN_NONE,
          op: OP_NONE, tx_ss: 1'b0, rlen: LEN_NONE};
    case (c)
      CMD_HALT: p.op = OP_HALT;
      CMD_RD_STATUS: p.tx_ss = 1'b1;
      CMD_WR_CTRL: begin
        p.wlen = LEN_BYTE;
        p.op = OP_WR_CTRL;
      end
      CMD_MEM_RD, CMD_MEM_RD_SS: begin
        p.need_addr = 1'b1;
        p.op = OP_MEM_RD;
        p.tx_ss = (c == CMD_MEM_RD_SS);
        p.rlen = LEN_BYTE;
      end
      CMD_MEM_RD_LAST: begin
        p.op = OP_MEM_RD_LAST;
        p.tx_ss = 1'b1;
        p.rlen = LEN_BYTE;
      end
      CMD_MEM_WR, CMD_MEM_WR_SS: begin
        p.need_addr = 1'b1;
        p.wlen = LEN_BYTE;
        p.op = OP_MEM_WR;
        p.tx_ss = (c == CMD_MEM_WR_SS);
      end
      CMD_RD_MATCH: begin
        p.op = OP_RD_MATCH;
        p.rlen = LEN_WORD;
      end
      CMD_WR_MATCH: begin
        p.wlen = LEN_WORD;
        p.op = OP_WR_MATCH;
      end
      CMD_GO: begin
        p.halted_only = 1'b1;
        p.op = OP_GO;
      end
      CMD_STEP: begin
        p.halted_only = 1'b1;
        p.op = OP_STEP;
      end
      CMD_TAG_GO: begin
        p.halted_only = 1'b1;
        p.op = OP_TAG_GO;
      end
      CMD_RD_ACC, CMD_RD_FLAGS: begin
        p.halted_only = 1'b1;
        p.op = OP_REG_RD;
        p.rlen = LEN_BYTE;
      end
      CMD_RD_PC, CMD_RD_HX, CMD_RD_SP: begin
        p.halted_only = 1'b1;
        p.op = OP_REG_RD;
        p.rlen = LEN_WORD;
      end
      CMD_WR_ACC, CMD_WR_FLAGS: begin
        p.halted_only = 1'b1;
        p.wlen = LEN_BYTE;
        p.op = OP_REG_WR;
      end
      CMD_WR_PC, CMD_WR_HX, CMD_WR_SP: begin
        p.halted_only = 1'b1;
        p.wlen = LEN_WORD;
        p.op = OP_REG_WR;
      end
      CMD_NEXT_RD, CMD_NEXT_RD_SS: begin
        p.halted_only = 1'b1;
        p.op = OP_NEXT_RD;
        p.tx_ss = (c == CMD_NEXT_RD_SS);
        p.rlen = LEN_BYTE;
      end
      CMD_NEXT_WR, CMD_NEXT_WR_SS: begin
        p.halted_only = 1'b1;
        p.wlen = LEN_BYTE;
        p.op = OP_NEXT_WR;
        p.tx_ss = (c == CMD_NEXT_WR_SS);
      end
      default: p.valid = 1'b0;
    endcase
    return p;
  endfunction

  // Bytes travel in the upper half so the shifter always sends bit 15 first
  function automatic logic [15:0] align(input swdc_len_t l, input logic [15:0] v);
    return (l == LEN_BYTE) ? {v[7:0], 8'h00} : v;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {M_CMD, M_ADDR, M_WDATA, M_EXEC, M_CAPT, M_TX_SS, M_TX_RD} swdc_phase_t;
  typedef struct packed {
    swdc_phase_t phase;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [15:0] tx;
    logic tx_en;
    swdc_plan_t plan;
    logic [2:0] sel;
    logic [15:0] addr;
    logic [15:0] last_addr;
    logic [15:0] rd;
    logic [7:0] ctrl;
    logic [15:0] match;
    logic halt;
    logic resume;
    logic step;
    logic tag;
    logic [2:0] reg_sel;
    logic reg_rd;
    logic reg_wr;
    logic [15:0] reg_wdata;
    logic mem_rd;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
  } swdc_port_state_t;

  swdc_port_state_t q, n;
  swdc_plan_t pl;
  logic [4:0] last_bit;
  logic [15:0] hx_next;
  logic [7:0] status;

  // The engine owns all line timing; the sequencer only ever sees whole bits
  swdc_bit_if bif ();

  swdc_bit_engine #(
    .TIMEOUT(TIMEOUT_CYC)
  ) u_eng (
    .mclk(mclk),
    .reset(reset),
    .line_in(debug_line_in),
    .line_out(debug_line_out),
    .line_oe(debug_line_oe),
    .bif(bif)
  );

  assign bif.tx_en = q.tx_en;
  assign bif.tx_bit = q.tx[15];

  always_comb begin
    n = q;
    pl = decode(q.sh[7:0]);
    hx_next = cpu_hx + 16'h0001;
    status = q.ctrl;
    status[HALTED_BIT_POS] = cpu_halted;
    n.halt = 1'b0;
    n.resume = 1'b0;
    n.step = 1'b0;
    n.tag = 1'b0;
    n.reg_rd = 1'b0;
    n.reg_wr = 1'b0;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    unique case (q.phase)
      M_ADDR: last_bit = LEN_WORD_BITS - 5'h01;
      M_WDATA, M_TX_RD: last_bit = ((q.phase == M_WDATA ? q.plan.wlen : q.plan.rlen) == LEN_BYTE)
                                   ? LEN_BYTE_BITS - 5'h01 : LEN_WORD_BITS - 5'h01;
      default: last_bit = LEN_BYTE_BITS - 5'h01;
    endcase
    if (bif.abort) begin
      // Nothing has been touched before the execute step, so dropping is clean
      n.phase = M_CMD;
      n.cnt = '0;
      n.tx_en = 1'b0;
    end else begin
      unique case (q.phase)
        M_CMD, M_ADDR, M_WDATA: begin
          if (bif.done) begin
            n.sh = {q.sh[14:0], bif.rx_bit};
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == last_bit) begin
              n.cnt = '0;
              pl = decode(n.sh[7:0]);
              if (q.phase == M_CMD) begin
                n.sel = n.sh[2:0];
                // Halted state is judged at decode only; a CPU that resumes mid-command is not caught
                if (pl.valid && (!pl.halted_only || cpu_halted)) begin
                  n.plan = pl;
                  n.phase = pl.need_addr ? M_ADDR : (pl.wlen != LEN_NONE) ? M_WDATA : M_EXEC;
                end
              end else if (q.phase == M_ADDR) begin
                n.addr = n.sh;
                n.phase = (q.plan.wlen != LEN_NONE) ? M_WDATA : M_EXEC;
              end else begin
                n.phase = M_EXEC;
              end
            end
          end
        end
        // Strobes fire two cycles after the done pulse of the last received bit; nothing waits for an ack
        M_EXEC: begin
          n.phase = M_CAPT;
          unique case (q.plan.op)
            OP_HALT: n.halt = q.ctrl[ENABLE_BIT_POS];
            OP_WR_CTRL: n.ctrl = q.sh[7:0];
            OP_MEM_RD: begin
              n.mem_rd = 1'b1;
              n.mem_addr = q.addr;
              n.last_addr = q.addr;
            end
            OP_MEM_RD_LAST: begin
              n.mem_rd = 1'b1;
              n.mem_addr = q.last_addr;
            end
            OP_MEM_WR: begin
              n.mem_wr = 1'b1;
              n.mem_addr = q.addr;
              n.mem_wdata = q.sh[7:0];
            end
            OP_WR_MATCH: n.match = q.sh;
            OP_GO: n.resume = 1'b1;
            OP_STEP: n.step = 1'b1;
            OP_TAG_GO: n.tag = 1'b1;
            OP_REG_RD: begin
              n.reg_rd = 1'b1;
              n.reg_sel = q.sel;
            end
            OP_REG_WR: begin
              n.reg_wr = 1'b1;
              n.reg_sel = q.sel;
              n.reg_wdata = (q.plan.wlen == LEN_BYTE) ? {8'h00, q.sh[7:0]} : q.sh;
            end
            OP_NEXT_RD, OP_NEXT_WR: begin
              n.reg_wr = 1'b1;
              n.reg_sel = REG_SEL_HX;
              n.reg_wdata = hx_next;
              n.mem_addr = hx_next;
              n.mem_rd = (q.plan.op == OP_NEXT_RD);
              n.mem_wr = (q.plan.op == OP_NEXT_WR);
              n.mem_wdata = q.sh[7:0];
              if (q.plan.op == OP_NEXT_RD) begin
                n.last_addr = hx_next;
              end
            end
            default: n.phase = M_CAPT;
          endcase
        end
        // Read data is taken at the end of the strobe cycle, so sources must answer at once
        M_CAPT: begin
          if (q.plan.op == OP_REG_RD) begin
            n.rd = reg_rdata;
          end else if (q.plan.op == OP_RD_MATCH) begin
            n.rd = q.match;
          end else begin
            n.rd = {8'h00, mem_rdata};
          end
          if (q.plan.tx_ss) begin
            n.phase = M_TX_SS;
            n.tx = {status, 8'h00};
            n.tx_en = 1'b1;
          end else if (q.plan.rlen != LEN_NONE) begin
            n.phase = M_TX_RD;
            n.tx = align(q.plan.rlen, n.rd);
            n.tx_en = 1'b1;
          end else begin
            n.phase = M_CMD;
          end
        end
        M_TX_SS, M_TX_RD: begin
          if (bif.done) begin
            n.tx = {q.tx[14:0], 1'b0};
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == last_bit) begin
              n.cnt = '0;
              if (q.phase == M_TX_SS && q.plan.rlen != LEN_NONE) begin
                n.phase = M_TX_RD;
                n.tx = align(q.plan.rlen, q.rd);
              end else begin
                n.phase = M_CMD;
                n.tx_en = 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    // Control byte starts clear, so halt requests stay off until the host enables them
    if (reset) begin
      q <= '{phase: M_CMD, plan: '{op: OP_NONE, wlen: LEN_NONE, rlen: LEN_NONE, default: '0},
             ctrl: CTRL_RESET, default: '0};
    end else begin
      q <= n;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign halt_req = q.halt;
  assign resume_req = q.resume;
  assign step_req = q.step;
  assign tag_req = q.tag;
  assign reg_sel = q.reg_sel;
  assign reg_rd = q.reg_rd;
  assign reg_wr = q.reg_wr;
  assign reg_wdata = q.reg_wdata;
  assign mem_rd = q.mem_rd;
  assign mem_wr = q.mem_wr;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;
  assign match_addr = q.match;
  assign status_ctrl = q.ctrl;
endmodule // swdc_port
`default_nettype wire

// >>> swdc_chk.sv
// Assertion checker bound to the debug command port
`default_nettype none
module swdc_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic debug_line_out,
  input wire logic debug_line_oe,
  input wire logic cpu_halted,
  input wire logic [15:0] cpu_hx,
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic step_req,
  input wire logic tag_req,
  input wire logic [2:0] reg_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] status_ctrl
);
  import swdc_pkg::*;
  logic [7:0] low_q;
  // Counts consecutive cycles of active low drive, saturating
  always_ff @(posedge mclk) begin
    if (reset || !(debug_line_oe && !debug_line_out))
      low_q <= 8'h00;
    else if (low_q != 8'hFF)
      low_q <= low_q + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  low_min_a: assert property (
    $rose(debug_line_oe) && !debug_line_out |-> (debug_line_oe && !debug_line_out)[*8] ##1
    (debug_line_oe && !debug_line_out)[*5]) else $error("low drive shorter than 13 cycles");
  low_count_a: assert property (
    debug_line_oe && debug_line_out && $past(debug_line_oe) |-> low_q == 8'h0D || low_q == 8'h80)
    else $error("speedup after wrong low length");
  speedup_len_a: assert property (
    debug_line_oe && debug_line_out |=> !debug_line_oe) else $error("speedup pulse not one cycle");
  halt_gate_a: assert property (
    halt_req |-> status_ctrl[ENABLE_BIT_POS]) else $error("halt without enable bit");
  halted_only_a: assert property (
    resume_req || step_req || tag_req || reg_rd || reg_wr |-> cpu_halted) else $error("halted-only op while running");
  step_once_a: assert property (
    step_req |=> !(step_req || resume_req || tag_req)) else $error("step request repeated");
  post_inc_a: assert property (
    reg_wr && (mem_rd || mem_wr) |-> reg_sel == REG_SEL_HX && mem_addr == reg_wdata &&
    reg_wdata == $past(cpu_hx) + 16'h0001) else $error("post increment address wrong");
  reg_sel_a: assert property (
    reg_rd |-> reg_sel inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h7}) else $error("bad register select");
endmodule // swdc_chk
bind swdc_port swdc_chk swdc_chk_inst (.mclk(mclk), .reset(reset), .debug_line_out(debug_line_out),
  .debug_line_oe(debug_line_oe), .cpu_halted(cpu_halted), .cpu_hx(cpu_hx), .halt_req(halt_req),
  .resume_req(resume_req), .step_req(step_req), .tag_req(tag_req), .reg_sel(reg_sel), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
  .status_ctrl(status_ctrl));
`default_nettype wire

// >>> swdc_host.sv
// Behavioural debug host pod clocking bits on the debug line
`default_nettype none
module swdc_host (
  input wire logic mclk,
  input wire logic line,
  output logic host_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_low = 1'b0;
  // A 1 releases early so the target may answer with its own drive
  task automatic bit_x(input logic b, output logic r);
    host_low <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      if ((i == 1 && b) || i == 15)
        host_low <= 1'b0;
      if (i == 9)
        r = line;
    end
  endtask
  task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] r);
    logic rb;
    r = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      bit_x(v[i], rb);
      r = {r[30:0], rb};
    end
  endtask
  task automatic gap();
    repeat (20) @(negedge mclk);
  endtask
  task automatic sync(output int n);
    n = 0;
    host_low <= 1'b1;
    repeat (140) @(negedge mclk);
    host_low <= 1'b0;
    // Let the release reach the wire before looking for the answer
    @(negedge mclk);
    for (int i = 0; i < 100 && line; i++) @(negedge mclk);
    while (!line && n < 300) begin
      n++;
      @(negedge mclk);
    end
  endtask
endmodule // swdc_host
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the debug command port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] c; int nw; logic [23:0] w; int nr; logic [15:0] e;} swdc_row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cpu_halted = 1'b0;
  logic [15:0] cpu_hx = 16'h0FFF;
  logic line, host_low, oe, lout, halt_req, resume_req, step_req, tag_req, reg_rd, reg_wr, mem_rd, mem_wr;
  logic [2:0] reg_sel;
  logic [15:0] reg_wdata, mem_addr, wa, ma;
  logic [7:0] mem_wdata, wd, sc;
  logic [18:0] rw;
  logic [31:0] r;
  int nh = 0;
  int ns = 0;
  int n_fail = 0;
  int comparisons = 0;
  int k;
  logic [7:0] wc [5] = '{8'h48, 8'h49, 8'h4B, 8'h4C, 8'h4F};
  swdc_row_t rows [17] = '{'{8'hE4, 0, 24'h0, 8, 16'h0000}, '{8'hE2, 0, 24'h0, 16, 16'h0000},
    '{8'hC4, 8, 24'h80, 0, 16'h0}, '{8'hE4, 0, 24'h0, 8, 16'h0080}, '{8'hC2, 16, 24'h8001, 0, 16'h0},
    '{8'hE2, 0, 24'h0, 16, 16'h8001}, '{8'hE0, 16, 24'h12A5, 8, 16'h005A}, '{8'hE1, 16, 24'h3, 16, 16'h80FC},
    '{8'hE8, 0, 24'h0, 16, 16'h80FC}, '{8'h68, 0, 24'h0, 8, 16'h00A0}, '{8'h69, 0, 24'h0, 8, 16'h00A1},
    '{8'h6B, 0, 24'h0, 16, 16'hC3A3}, '{8'h6C, 0, 24'h0, 16, 16'hC3A4}, '{8'h6F, 0, 24'h0, 16, 16'hC3A7},
    '{8'h70, 0, 24'h0, 8, 16'h00FF}, '{8'h71, 0, 24'h0, 16, 16'hC0FF}, '{8'hE4, 0, 24'h0, 8, 16'h00C0}};
  always #10 mclk = ~mclk;
  // Pull-up: the wire is high unless someone drives it
  assign line = oe ? lout : !host_low;
  swdc_port swdc_port_inst (.mclk(mclk), .reset(reset), .debug_line_in(line), .debug_line_out(lout),
    .debug_line_oe(oe), .cpu_halted(cpu_halted), .cpu_hx(cpu_hx), .halt_req(halt_req),
    .resume_req(resume_req), .step_req(step_req), .tag_req(tag_req), .reg_sel(reg_sel), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata({8'hC3, 5'h14, reg_sel}), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(~mem_addr[7:0]),
    .match_addr(ma), .status_ctrl(sc));
  swdc_host swdc_host_inst (.mclk(mclk), .line(line), .host_low(host_low));
  always @(posedge mclk) begin
    if (mem_wr) begin
      wa <= mem_addr;
      wd <= mem_wdata;
    end
    if (reg_wr)
      rw <= {reg_sel, reg_wdata};
    nh <= nh + int'(halt_req);
    ns <= ns + int'(resume_req) + int'(step_req) + int'(tag_req);
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input int n, input logic [31:0] v);
    swdc_host_inst.xfer(n, v, r);
    swdc_host_inst.gap();
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 17; i++) begin
      cpu_halted = (i > 8);
      cmd(8 + rows[i].nw, ({24'h0, rows[i].c} << rows[i].nw) | {8'h00, rows[i].w});
      swdc_host_inst.xfer(rows[i].nr, 32'hFFFF_FFFF, r);
      if (rows[i].nr > 0)
        chk("read", r[15:0], rows[i].e);
      $display("row %0d done", i);
    end
    chk("match", ma, 16'h8001);
    chk("ctrl", {8'h00, sc}, 16'h0080);
    cpu_halted = 1'b0;
    cmd(32, 32'hC012_345A);
    chk("waddr", wa, 16'h1234);
    chk("wdata", {8'h00, wd}, 16'h005A);
    cmd(32, 32'hC1AB_CD3C);
    swdc_host_inst.xfer(8, 32'hFF, r);
    chk("wstat", r[15:0], 16'h0080);
    chk("waddr", wa, 16'hABCD);
    cmd(8, 32'h08);
    cmd(8, 32'hD5);
    chk("runpulse", ns[15:0], 16'h0000);
    cmd(8, 32'h90);
    chk("halt", nh[15:0], 16'h0001);
    cmd(16, 32'hC400);
    cmd(8, 32'h90);
    chk("nohalt", nh[15:0], 16'h0001);
    $display("running test done");
    cpu_halted = 1'b1;
    for (int j = 0; j < 5; j++) begin
      k = (wc[j][2:1] != 2'b00) ? 16 : 8;
      cmd(8 + k, ({24'h0, wc[j]} << k) | (32'h1357 & ~(32'hFFFF_FFFF << k)));
      chk("regwr", rw[15:0], k == 16 ? 16'h1357 : 16'h0057);
      chk("regsel", {13'h0000, rw[18:16]}, {13'h0000, wc[j][2:0]});
    end
    cmd(16, 32'h503C);
    chk("naddr", wa, 16'h1000);
    chk("ndata", {8'h00, wd}, 16'h003C);
    cmd(8, 32'h08);
    cmd(8, 32'h10);
    cmd(8, 32'h18);
    chk("go", ns[15:0], 16'h0003);
    $display("halted test done");
    swdc_host_inst.xfer(12, 32'hC4F, r);
    repeat (600) @(negedge mclk);
    swdc_host_inst.xfer(8, 32'hE4, r);
    swdc_host_inst.xfer(8, 32'hFF, r);
    chk("abort", r[15:0], 16'h0040);
    swdc_host_inst.sync(k);
    chk("sync", k[15:0], 16'h0080);
    $display("abort and sync test done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
